// ===== design/queued_dma_write_regs.svh
/*
  Register offsets, bit positions, command codes and reset values of the
  queued DMA write status block.
  Assumes a byte-addressed APB slave with 32-bit data; each register is one word.
*/
`ifndef QUEUED_DMA_WRITE_REGS_SVH
`define QUEUED_DMA_WRITE_REGS_SVH

`define OFF_ERR 8'h00
`define OFF_CNT 8'h04
`define OFF_ALO 8'h08
`define OFF_AMI 8'h0C
`define OFF_AHI 8'h10
`define OFF_DRV 8'h14
`define OFF_STS 8'h18
`define OFF_CMD 8'h1C
`define OFF_CTL 8'h20
`define OFF_CFG 8'h24

`define ST_BUSY 7
`define ST_RDY 6
`define ST_FLT 5
`define ST_SERVICE_PENDING_FLAG 4
`define ST_DRQ 3
`define ST_ERR 0

`define ER_INTERFACE_CHECKSUM_ERROR 7
`define ER_WP 6
`define ER_MC 5
`define ER_NF 4
`define ER_MCR 3
`define ER_ABORTED_FLAG 2
`define ER_NM 1

`define TAG_HI 7
`define TAG_LO 3
`define CNT_REL 2
`define CNT_IO 1
`define CNT_CD 0

`define CTL_HOB 7
`define CTL_OVL 1
`define CFG_QUE 0
`define CFG_SUP 1

`define CMD_QWRITE 8'h36
`define CMD_SERVICE 8'h5A

`define RST_STS 8'h40
`define RST_CFG 8'h03
`define NUM_TAGS 32

`endif

// ===== design/queued_dma_write_pkg.sv
/*
  Types of the queued DMA write status block.
  Assumes the constants header is included by the design file.
*/
package queued_dma_write_pkg;

  typedef enum logic {ST_IDLE, ST_XFER} state_t;

  typedef enum logic [2:0] {TQ_FREE, TQ_WAIT, TQ_READY, TQ_XFER, TQ_FAIL} tq_t;

endpackage

// ===== design/queued_dma_write_status.sv
/*
  Device-side result reporting and bus-release control for the queued
  48-bit DMA write command, with its task-file registers on APB.
  Assumes the data path runs on clk_sys and gives one-cycle event pulses.
*/
`timescale 1ns/1ps
`include "queued_dma_write_regs.svh"

module queued_dma_write_status
  import queued_dma_write_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data path events
  input wire logic path_ready,
  input wire logic ev_ready,
  input wire logic ev_done,
  input wire logic ev_err,
  input wire logic [4:0] ev_tag,
  input wire logic [47:0] fail_addr,
  input wire logic err_crc,
  input wire logic err_udma,
  input wire logic err_nf,
  input wire logic err_range,
  input wire logic err_fault,
  // removable media
  input wire logic media_wp,
  input wire logic media_absent,
  input wire logic media_changed,
  input wire logic media_chg_req,
  input wire logic media_status_query,
  // data path control
  output logic xfer_start,
  output logic [4:0] xfer_tag,
  output logic queue_abort
);

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations and helpers

  state_t state_reg;
  tq_t tq_reg [`NUM_TAGS];
  logic [47:0] fa_reg [`NUM_TAGS];
  logic [7:0] fe_reg [`NUM_TAGS];
  logic ff_reg [`NUM_TAGS];
  logic [4:0] cur_tag_reg;
  logic [7:0] err_reg, cnt_reg, cnt_prev_reg, drv_reg, sts_reg;
  logic [7:0] ctl_reg, cfg_reg;
  logic [47:0] addr_reg;
  logic mc_pend_reg, mcr_reg;
  logic acc, wr, cmd_we, qw, sv, queued;
  logic qw_ok, qw_bad, sv_take, sv_bad, x_err, x_done, bg_err, bg_rdy;
  logic svc_found;
  logic [4:0] new_tag, svc_tag;
  logic [7:0] live_err, rd_byte;
  logic hit, high_order_select;

  // lowest tag that needs service; bias to low tags is accepted
  function automatic logic [5:0] pick_service_pending_flag(input tq_t q [`NUM_TAGS]);
    logic [5:0] r;
    r = 6'h00;
    for (int i = `NUM_TAGS - 1; i >= 0; i--) begin
      if (q[i] == TQ_READY || q[i] == TQ_FAIL) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] mk_cnt(input logic [4:0] t, input logic release_flag,
                                        input logic fin);
    logic [7:0] c;
    c = 8'h00;
    c[`TAG_HI:`TAG_LO] = t;
    c[`CNT_REL] = release_flag;
    c[`CNT_IO] = fin;
    c[`CNT_CD] = fin;
    return c;
  endfunction

  function automatic logic [7:0] mk_sts(input logic flt, input logic service_pending_flag,
                                        input logic err);
    logic [7:0] s;
    s = 8'h00;
    s[`ST_RDY] = 1'b1;
    s[`ST_FLT] = flt;
    s[`ST_SERVICE_PENDING_FLAG] = service_pending_flag;
    s[`ST_ERR] = err;
    return s;
  endfunction

  function automatic logic [7:0] mk_err(input logic crc, input logic udma,
                                        input logic nf, input logic range,
                                        input logic unsup);
    logic [7:0] e;
    logic a0;
    e = 8'h00;
    a0 = unsup | udma;
    e[`ER_INTERFACE_CHECKSUM_ERROR] = crc & udma;
    e[`ER_NF] = nf | (range & ~a0);
    e[`ER_ABORTED_FLAG] = a0 | (range & ~e[`ER_NF]);
    e[`ER_WP] = media_wp;
    e[`ER_NM] = media_absent;
    e[`ER_MC] = mc_pend_reg;
    e[`ER_MCR] = mcr_reg;
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // command and event decode

  always_comb begin
    acc = psel && penable && pready;
    wr = acc && pwrite;
    cmd_we = wr && paddr == `OFF_CMD;
    qw = cmd_we && pwdata[7:0] == `CMD_QWRITE;
    sv = cmd_we && pwdata[7:0] == `CMD_SERVICE;
    queued = cfg_reg[`CFG_QUE] && ctl_reg[`CTL_OVL];
    new_tag = queued ? cnt_reg[`TAG_HI:`TAG_LO] : 5'h00;
    qw_bad = qw && state_reg == ST_IDLE && (!cfg_reg[`CFG_SUP] ||
             !ctl_reg[`CTL_OVL] ||
             tq_reg[new_tag] != TQ_FREE);
    // a new command during data movement is ignored
    qw_ok = qw && state_reg == ST_IDLE && !qw_bad;
    {svc_found, svc_tag} = pick_service_pending_flag(tq_reg);
    sv_take = sv && svc_found && state_reg == ST_IDLE;
    sv_bad = sv && !svc_found && state_reg == ST_IDLE;
    x_err = state_reg == ST_XFER && ev_err && ev_tag == cur_tag_reg;
    x_done = state_reg == ST_XFER && ev_done && ev_tag == cur_tag_reg && !x_err;
    bg_err = ev_err && !x_err && !qw && !sv &&
             (tq_reg[ev_tag] == TQ_WAIT || tq_reg[ev_tag] == TQ_READY);
    bg_rdy = ev_ready && !qw && !sv && tq_reg[ev_tag] == TQ_WAIT;
    live_err = mk_err(err_crc, err_udma, err_nf, err_range, 1'b0);
  end

  ////////////////////////////////////////////////////////////////////////
  // per-tag table

  genvar g;
  generate
    for (g = 0; g < `NUM_TAGS; g++) begin : tags
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          tq_reg[g] <= TQ_FREE;
          fa_reg[g] <= 48'h0;
          fe_reg[g] <= 8'h00;
          ff_reg[g] <= 1'b0;
        end else if (x_err) begin
          tq_reg[g] <= TQ_FREE;
        end else if (bg_err) begin
          if (5'(g) == ev_tag) begin
            tq_reg[g] <= TQ_FAIL;
            fa_reg[g] <= fail_addr;
            fe_reg[g] <= live_err;
            ff_reg[g] <= err_fault;
          end else begin
            tq_reg[g] <= TQ_FREE;
          end
        end else if (qw_ok && 5'(g) == new_tag) begin
          tq_reg[g] <= path_ready ? TQ_XFER : TQ_WAIT;
        end else if (sv_take && 5'(g) == svc_tag) begin
          tq_reg[g] <= tq_reg[g] == TQ_READY ? TQ_XFER : TQ_FREE;
        end else if (x_done && 5'(g) == cur_tag_reg) begin
          tq_reg[g] <= TQ_FREE;
        end else if (bg_rdy && 5'(g) == ev_tag) begin
          tq_reg[g] <= TQ_READY;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // media flags

  // a new event in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mc_pend_reg <= 1'b0;
      mcr_reg <= 1'b0;
    end else begin
      if (media_changed) begin
        mc_pend_reg <= 1'b1;
      end else if (x_err || bg_err || qw_bad || sv_bad) begin
        mc_pend_reg <= 1'b0;
      end
      if (media_chg_req) begin
        mcr_reg <= 1'b1;
      end else if (media_status_query || qw_ok) begin
        mcr_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= 8'h00;
      cfg_reg <= `RST_CFG;
      drv_reg <= 8'h00;
    end else if (wr) begin
      if (paddr == `OFF_CTL) begin
        ctl_reg <= pwdata[7:0];
      end
      if (paddr == `OFF_CFG) begin
        cfg_reg <= pwdata[7:0];
      end
      if (paddr == `OFF_DRV) begin
        drv_reg <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register images and command sequence

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cur_tag_reg <= 5'h00;
      err_reg <= 8'h00;
      cnt_reg <= 8'h00;
      cnt_prev_reg <= 8'h00;
      addr_reg <= 48'h0;
      sts_reg <= `RST_STS;
      xfer_start <= 1'b0;
      xfer_tag <= 5'h00;
      queue_abort <= 1'b0;
    end else begin
      xfer_start <= 1'b0;
      queue_abort <= 1'b0;
      if (qw_bad || sv_bad) begin
        err_reg <= mk_err(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        cnt_reg <= mk_cnt(new_tag, 1'b0, 1'b1);
        cnt_prev_reg <= 8'h00;
        sts_reg <= mk_sts(1'b0, svc_found, 1'b1);
      end else if (qw_ok) begin
        cur_tag_reg <= new_tag;
        cnt_prev_reg <= 8'h00;
        err_reg <= 8'h00;
        if (path_ready) begin
          state_reg <= ST_XFER;
          cnt_reg <= mk_cnt(new_tag, 1'b0, 1'b0);
          sts_reg <= mk_sts(1'b0, 1'b0, 1'b0);
          xfer_start <= 1'b1;
          xfer_tag <= new_tag;
        end else begin
          cnt_reg <= mk_cnt(new_tag, 1'b1, 1'b0);
          sts_reg <= mk_sts(1'b0, svc_found, 1'b0);
        end
      end else if (sv_take) begin
        cnt_prev_reg <= 8'h00;
        if (tq_reg[svc_tag] == TQ_READY) begin
          state_reg <= ST_XFER;
          cur_tag_reg <= svc_tag;
          err_reg <= 8'h00;
          cnt_reg <= mk_cnt(svc_tag, 1'b0, 1'b0);
          sts_reg <= mk_sts(1'b0, 1'b0, 1'b0);
          xfer_start <= 1'b1;
          xfer_tag <= svc_tag;
        end else begin
          err_reg <= fe_reg[svc_tag];
          cnt_reg <= mk_cnt(svc_tag, 1'b0, 1'b1);
          addr_reg <= fa_reg[svc_tag];
          sts_reg <= mk_sts(ff_reg[svc_tag], 1'b0, fe_reg[svc_tag] != 8'h00);
        end
      end else if (x_err) begin
        state_reg <= ST_IDLE;
        err_reg <= live_err;
        cnt_reg <= mk_cnt(cur_tag_reg, 1'b0, 1'b1);
        cnt_prev_reg <= 8'h00;
        addr_reg <= fail_addr;
        sts_reg <= mk_sts(err_fault, 1'b0, live_err != 8'h00);
        queue_abort <= 1'b1;
      end else if (x_done) begin
        state_reg <= ST_IDLE;
        err_reg <= 8'h00;
        cnt_reg <= mk_cnt(cur_tag_reg, 1'b0, 1'b1);
        cnt_prev_reg <= 8'h00;
        sts_reg <= mk_sts(1'b0, svc_found, 1'b0);
      end else begin
        if (bg_err) begin
          queue_abort <= 1'b1;
        end
        if (bg_rdy || bg_err) begin
          sts_reg[`ST_SERVICE_PENDING_FLAG] <= 1'b1;
        end
        if (wr && paddr == `OFF_CNT) begin
          cnt_prev_reg <= cnt_reg;
          cnt_reg <= pwdata[7:0];
        end
        if (wr && paddr == `OFF_ALO) begin
          addr_reg[31:24] <= addr_reg[7:0];
          addr_reg[7:0] <= pwdata[7:0];
        end
        if (wr && paddr == `OFF_AMI) begin
          addr_reg[39:32] <= addr_reg[15:8];
          addr_reg[15:8] <= pwdata[7:0];
        end
        if (wr && paddr == `OFF_AHI) begin
          addr_reg[47:40] <= addr_reg[23:16];
          addr_reg[23:16] <= pwdata[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb read mux and handshake

  always_comb begin
    high_order_select = ctl_reg[`CTL_HOB];
    hit = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      `OFF_ERR: rd_byte = err_reg;
      `OFF_CNT: rd_byte = high_order_select ? cnt_prev_reg : cnt_reg;
      `OFF_ALO: rd_byte = high_order_select ? addr_reg[31:24] : addr_reg[7:0];
      `OFF_AMI: rd_byte = high_order_select ? addr_reg[39:32] : addr_reg[15:8];
      `OFF_AHI: rd_byte = high_order_select ? addr_reg[47:40] : addr_reg[23:16];
      `OFF_DRV: rd_byte = drv_reg;
      `OFF_STS: rd_byte = sts_reg;
      `OFF_CMD: rd_byte = 8'h00;
      `OFF_CTL: rd_byte = ctl_reg;
      `OFF_CFG: rd_byte = cfg_reg;
      default: hit = 1'b0;
    endcase
  end

  // one wait state so that read data comes from a flip-flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0 : {24'h0, rd_byte};
        pslverr <= !hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule

// ===== tb/queued_dma_write_status_props.sv
/*
  Checker for the queued DMA write status block, watching its top-level ports.
  Assumes the constants header is on the include path.
*/
`timescale 1ns/1ps
`include "queued_dma_write_regs.svh"

module status_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // data path
  input wire logic ev_done,
  input wire logic ev_err,
  input wire logic xfer_start,
  input wire logic [4:0] xfer_tag,
  input wire logic queue_abort
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  logic moving;
  logic cmd_commit;
  // a start while still moving would be a second release mid-transfer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      moving <= 1'b0;
    end else if (xfer_start) begin
      moving <= 1'b1;
    end else if (ev_done || queue_abort) begin
      moving <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmd_commit <= 1'b0;
    end else begin
      cmd_commit <= psel && penable && pready && pwrite && paddr == `OFF_CMD;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_wait_state: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_write_rdata_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_abort_cause: assert property (queue_abort |-> $past(ev_err))
    else $error("queue abort without error event");
  chk_start_cause: assert property (xfer_start |-> cmd_commit)
    else $error("transfer start without command commit");
  chk_no_restart: assert property (xfer_start |-> !moving)
    else $error("transfer restarted before completion");
  chk_tag_hold: assert property (!xfer_start |-> $stable(xfer_tag))
    else $error("transfer tag changed without start");
  cover property (xfer_start);
  cover property (queue_abort);
  cover property (pready && pslverr);
  cover property (pready && !pwrite);
endmodule

bind queued_dma_write_status status_props u_props (.clk_sys(clk_sys), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ev_done(ev_done), .ev_err(ev_err),
  .xfer_start(xfer_start), .xfer_tag(xfer_tag), .queue_abort(queue_abort));

// ===== tb/data_path_model.sv
/*
  Behavioural data path: reports readiness, or a failure when fail is set,
  of released tags on request, and
  ends each started transfer after a set delay, cleanly or with an error.
  Assumes the bench sets delay and failure mode before each start.
*/
`timescale 1ns/1ps

module data_path_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // from the status block
  input wire logic xfer_start,
  input wire logic [4:0] xfer_tag,
  // bench controls
  input wire logic rdy_req,
  input wire logic [4:0] rdy_tag,
  input wire logic fail,
  input wire logic [47:0] addr_in,
  input wire logic [3:0] lat,
  // events
  output logic ev_ready,
  output logic ev_done,
  output logic ev_err,
  output logic [4:0] ev_tag,
  output logic [47:0] fail_addr
);
  logic busy_reg;
  logic [3:0] cnt_reg;
  logic [4:0] tag_reg;
  // idle tag and address flip each cycle so stale values are never trusted
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      tag_reg <= 5'h00;
      ev_ready <= 1'b0;
      ev_done <= 1'b0;
      ev_err <= 1'b0;
      ev_tag <= 5'h00;
      fail_addr <= 48'h0;
    end else begin
      ev_ready <= 1'b0;
      ev_done <= 1'b0;
      ev_err <= 1'b0;
      ev_tag <= ~ev_tag;
      fail_addr <= ~fail_addr;
      if (xfer_start) begin
        busy_reg <= 1'b1;
        cnt_reg <= lat;
        tag_reg <= xfer_tag;
      end else if (busy_reg && cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
        ev_done <= !fail;
        ev_err <= fail;
        ev_tag <= tag_reg;
        fail_addr <= addr_in;
      end else if (rdy_req) begin
        ev_ready <= !fail;
        ev_err <= fail;
        ev_tag <= rdy_tag;
        fail_addr <= addr_in;
      end
    end
  end
endmodule

// ===== tb/test_queued_dma_write_status.sv
/*
  Self-checking bench of the queued DMA write status block over APB.
  Assumes the data path model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "queued_dma_write_regs.svh"

module test_queued_dma_write_status
  import queued_dma_write_pkg::*;
;
  logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, perr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h5D704C2A;
  logic pready, pslverr, xfer_start, queue_abort, ev_ready, ev_done, ev_err;
  logic [4:0] xfer_tag, ev_tag, a, b, t, rdy_tag = 5'h00;
  logic [47:0] fail_addr, fa = 48'h0;
  logic path_ready = 1'b0, err_crc = 1'b0, err_udma = 1'b0, err_nf = 1'b0;
  logic err_range = 1'b0, err_fault = 1'b0, media_wp = 1'b0, media_absent = 1'b0;
  logic rdy_req = 1'b0, fail = 1'b0;
  logic media_changed = 1'b0, media_chg_req = 1'b0, media_status_query = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [7:0] r;
  logic [4:0] cs [4] = '{5'b11000, 5'b00100, 5'b00010, 5'b01011};
  int error_cnt = 0, n_tests = 0, qa_cnt = 0;

  always #12.5 clk_sys = ~clk_sys;

  queued_dma_write_status dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .path_ready(path_ready), .ev_ready(ev_ready),
    .ev_done(ev_done), .ev_err(ev_err), .ev_tag(ev_tag), .fail_addr(fail_addr),
    .err_crc(err_crc), .err_udma(err_udma), .err_nf(err_nf), .err_range(err_range),
    .err_fault(err_fault), .media_wp(media_wp), .media_absent(media_absent),
    .media_changed(media_changed), .media_chg_req(media_chg_req),
    .media_status_query(media_status_query),
    .xfer_start(xfer_start), .xfer_tag(xfer_tag), .queue_abort(queue_abort));

  data_path_model u_path (.clk_sys(clk_sys), .nrst(nrst), .xfer_start(xfer_start),
    .xfer_tag(xfer_tag), .rdy_req(rdy_req), .rdy_tag(rdy_tag), .fail(fail), .addr_in(fa),
    .lat(lat), .ev_ready(ev_ready), .ev_done(ev_done), .ev_err(ev_err), .ev_tag(ev_tag),
    .fail_addr(fail_addr));

  always @(posedge clk_sys) if (queue_abort === 1'b1) qa_cnt <= qa_cnt + 1;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // q is {crc, udma, nf, range, fault}; range alone reports not-found
  function automatic logic [7:0] exp_err(input logic [4:0] q, input logic w, m);
    return {q[4] & q[3], w, 1'b0, q[2] | (q[1] & !q[3]), 1'b0, q[3], m, 1'b0};
  endfunction
  task automatic conclude;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, d, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rd = prdata[7:0];
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, d);
    logic [7:0] x;
    apb(1'b1, ad, d, x);
  endtask
  task automatic rc(input logic [7:0] ad, e);
    logic [7:0] x;
    apb(1'b0, ad, 8'h00, x);
    chk(x, e);
  endtask
  task automatic ready(input logic [4:0] tg);
    @(posedge clk_sys);
    rdy_req <= 1'b1;
    rdy_tag <= tg;
    @(posedge clk_sys);
    rdy_req <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wait_end;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ev_done !== 1'b1 && ev_err !== 1'b1 && n < 100);
    if (n >= 100) error_cnt++;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rc(`OFF_STS, 8'h40);
    rc(`OFF_ERR, 8'h00);
    apb(1'b0, 8'h30, 8'h00, r);
    chk({7'h0, perr}, 8'h01);
    chk(r, 8'h00);
    wr(`OFF_CTL, 8'h02);
    // two released tags, served lowest first
    seed = lfsr(seed);
    a = 5'(seed % 31);
    b = a + 5'h01;
    wr(`OFF_CNT, {a, 3'b000});
    wr(`OFF_CMD, `CMD_QWRITE);
    rc(`OFF_CNT, {a, 3'b100});
    wr(`OFF_CNT, {b, 3'b000});
    wr(`OFF_CMD, `CMD_QWRITE);
    rc(`OFF_STS, 8'h40);
    ready(a);
    rc(`OFF_STS, 8'h50);
    rc(`OFF_CNT, {b, 3'b100});
    ready(b);
    for (int i = 0; i < 2; i++) begin
      t = i ? b : a;
      lat <= 4'h8 | seed[3:0];
      wr(`OFF_CMD, `CMD_SERVICE);
      rc(`OFF_CNT, {t, 3'b000});
      chk({3'b0, xfer_tag}, {3'b0, t});
      wait_end();
      rc(`OFF_CNT, {t, 3'b011});
      rc(`OFF_STS, i ? 8'h40 : 8'h50);
    end
    // errors on immediate transfers
    path_ready <= 1'b1;
    fail <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      t = seed[4:0];
      fa <= {seed[15:0], seed};
      {err_crc, err_udma, err_nf, err_range, err_fault} <= cs[i];
      media_wp <= seed[5];
      media_absent <= seed[6];
      lat <= seed[3:0];
      wr(`OFF_CNT, {t, 3'b000});
      wr(`OFF_CMD, `CMD_QWRITE);
      wait_end();
      rc(`OFF_ERR, exp_err(cs[i], seed[5], seed[6]));
      rc(`OFF_STS, {2'b01, cs[i][0], 4'h0, 1'b1});
      rc(`OFF_CNT, {t, 3'b011});
      for (int h = 1; h >= 0; h--) begin
        wr(`OFF_CTL, {h[0], 7'h02});
        for (int j = 0; j < 3; j++) rc(`OFF_ALO + 8'(4 * j), fa[24 * h + 8 * j +: 8]);
      end
      chk(8'(qa_cnt), 8'(i + 1));
    end
    // refused commands
    {path_ready, fail, err_crc, err_udma, err_nf, err_range, err_fault} <= 7'h00;
    media_wp <= 1'b0;
    media_absent <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      t = seed[4:0];
      wr(`OFF_CTL, k == 0 ? 8'h00 : 8'h02);
      wr(`OFF_CFG, k == 1 ? 8'h01 : 8'h03);
      // media events: change and request first, then a status query
      if (k != 1) begin
        @(posedge clk_sys);
        media_changed <= k == 0;
        media_chg_req <= k == 0;
        media_status_query <= k == 2;
        @(posedge clk_sys);
        {media_changed, media_chg_req, media_status_query} <= 3'b000;
      end
      if (k == 2) wr(`OFF_CNT, {t, 3'b000});
      if (k == 2) wr(`OFF_CMD, `CMD_QWRITE);
      wr(`OFF_CNT, {t, 3'b000});
      wr(`OFF_CMD, `CMD_QWRITE);
      rc(`OFF_ERR, {2'b00, k == 0, 1'b0, k < 2, 3'b100});
      rc(`OFF_STS, 8'h41);
      apb(1'b0, `OFF_CNT, 8'h00, r);
      if (k == 0) chk({3'b0, r[7:3]}, 8'h00);
    end
    // background failure of a released tag, reported at the next service
    seed = lfsr(seed);
    fa <= {seed, seed[31:16]};
    {fail, err_nf} <= 2'b11;
    ready(t);
    rc(`OFF_STS, 8'h51);
    {fail, err_nf} <= 2'b00;
    wr(`OFF_CMD, `CMD_SERVICE);
    rc(`OFF_ERR, 8'h10);
    rc(`OFF_STS, 8'h41);
    rc(`OFF_CNT, {t, 3'b011});
    for (int j = 0; j < 3; j++) rc(`OFF_ALO + 8'(4 * j), fa[8 * j +: 8]);
    chk(8'(qa_cnt), 8'h05);
    // service with nothing pending is refused
    wr(`OFF_CMD, `CMD_SERVICE);
    rc(`OFF_ERR, 8'h04);
    rc(`OFF_STS, 8'h41);
    wr(`OFF_CTL, 8'h82);
    rc(`OFF_CNT, 8'h00);
    conclude();
  end
endmodule
